// File: hw/deep_sleep_wake_pkg.sv
// Purpose: constants and carrier types for the deep-sleep wake status block
// Assumes: byte-wide register port, 125 MHz clock
// Notes: register offsets are the byte addresses of the plain register port
package deep_sleep_wake_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_WAKE_LOW  = 12'hf4a;
  localparam logic [11:0] ADDR_WAKE_HIGH = 12'hf4b;
  localparam logic [11:0] ADDR_SCRATCH0  = 12'hf4e;
  localparam logic [11:0] ADDR_SCRATCH1  = 12'hf4f;
  localparam logic [11:0] ADDR_WDT_CTRL  = 12'hf50;

  // wake_status_low field positions
  localparam int BIT_FAULT = 7;
  localparam int BIT_ULP   = 5;
  localparam int BIT_WDT   = 4;
  localparam int BIT_RTC   = 3;
  localparam int BIT_RSTPIN = 2;
  localparam int BIT_POR   = 0;
  // wake_status_high field position
  localparam int BIT_IOC   = 0;
  // watchdog_control_reg field positions
  localparam int BIT_LEVEL = 5;
  localparam int BIT_MODEN = 1;
  localparam int BIT_SINKEN = 0;

  // implemented bit masks and reset values
  localparam logic [7:0] MASK_WAKE_LOW  = 8'hbd;
  localparam logic [7:0] MASK_WAKE_HIGH = 8'h01;
  localparam logic [7:0] MASK_WDT_CTRL  = 8'h23;
  localparam logic [7:0] RST_WAKE_LOW   = 8'h01;
  localparam logic [7:0] RST_WAKE_HIGH  = 8'h00;
  localparam logic [7:0] RST_WDT_CTRL   = 8'h00;
  localparam logic [7:0] RST_SCRATCH    = 8'h00;

  // power modes of the core
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_t;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // wake event sources, all synchronised
  typedef struct packed {
    logic fault;
    logic ulp;
    logic wdt;
    logic rtc;
    logic rstPin;
    logic ioc;
  } wake_src_t;

endpackage : deep_sleep_wake_pkg

// File: hw/sync_bits.sv
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
module sync_bits #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  // state of the synchroniser
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;

  // shift the two stages
  always_comb begin
    next_state.meta   = asyncIn;
    next_state.stable = state.meta;
  end

  // register the stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stable;
endmodule : sync_bits
`default_nettype wire

// File: hw/wake_first_select.sv
// Purpose: picks the first wake source to assert during deep sleep
// Assumes: sources synchronised, armed rises when deep sleep starts
// Notes: simultaneous sources resolve by fixed priority, fault first
`timescale 1ns/10ps
`default_nettype none
module wake_first_select (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           armed,
  input  wire deep_sleep_wake_pkg::wake_src_t src,
  output var  deep_sleep_wake_pkg::wake_src_t first
);
  // latch: which source was first, and whether one was taken
  typedef struct packed {
    deep_sleep_wake_pkg::wake_src_t pick;
    logic                           taken;
  } first_state_t;
  first_state_t state;
  first_state_t next_state;

  // one-hot priority pick of the active sources
  function automatic deep_sleep_wake_pkg::wake_src_t onehot(
    input deep_sleep_wake_pkg::wake_src_t s);
    deep_sleep_wake_pkg::wake_src_t r;
    r = '0;
    if (s.fault) begin
      r.fault = 1'b1;
    end else if (s.ulp) begin
      r.ulp = 1'b1;
    end else if (s.wdt) begin
      r.wdt = 1'b1;
    end else if (s.rtc) begin
      r.rtc = 1'b1;
    end else if (s.rstPin) begin
      r.rstPin = 1'b1;
    end else if (s.ioc) begin
      r.ioc = 1'b1;
    end
    return r;
  endfunction : onehot

  always_comb begin
    next_state = state;
    if (!armed) begin
      // cleared whenever deep sleep is not running
      next_state = '0;
    end else if (!state.taken && (src != '0)) begin
      next_state.pick  = onehot(src);
      next_state.taken = 1'b1;
    end
  end

  // register the latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign first = state.pick;

  a_first_onehot: assert property (@(posedge clk) disable iff (!resetn)
    $onehot0(state.pick))
    else $error("more than one wake source latched");
  a_first_holds: assert property (@(posedge clk) disable iff (!resetn)
    (state.taken && armed) |=> $stable(state.pick))
    else $error("latched wake source changed");
endmodule : wake_first_select
`default_nettype wire

// File: hw/deep_sleep_wake_status.sv
// Purpose: deep-sleep retention scratch, wake-source log, pin discharge wake-up
// Assumes: register port on clk; event inputs come from other clock domains
// Notes: porEvent is the supply power-on event; resetn is the core reset
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_wake_status (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire deep_sleep_wake_pkg::reg_req_t regReq,
  output var  logic [7:0]                    rdata,
  input  wire logic                          sleepReq,
  input  wire logic                          deepSleepReq,
  input  wire logic                          porEvent,
  input  wire logic                          coreBrownout,
  input  wire logic                          sleepBrownout,
  input  wire logic                          sleepBrownoutEnable,
  input  wire logic                          faultDetect,
  input  wire logic                          watchdogTimeout,
  input  wire logic                          alarmEvent,
  input  wire logic                          resetPinEvent,
  input  wire logic                          iocEvent,
  input  wire logic                          wakeDischargePinIn,
  output var  logic                          wakeDischargePinOut,
  output var  logic                          wakeDischargePinOe,
  output var  logic                          dischargeWakeOutput,
  output var  logic                          coreWake,
  output var  logic                          porSequenceReq,
  output var  logic                          inDeepSleep
);
  // all state of the block
  typedef struct packed {
    deep_sleep_wake_pkg::power_mode_t mode;       // current power mode
    logic [7:0]                       wakeLow;    // wake_status_low
    logic [7:0]                       wakeHigh;   // wake_status_high
    logic [7:0]                       scratch0;   // persistent_scratch_0
    logic [7:0]                       scratch1;   // persistent_scratch_1
    logic [7:0]                       wdtCtrl;    // watchdog_control_reg
    logic [7:0]                       rdata;      // read answer
    logic                             sinkOn;     // pin sink drive
    logic                             wakeOut;    // remappable wake output
    logic                             coreWake;   // wake pulse to core
    logic                             porReq;     // power-on sequence pulse
    logic                             deepOut;    // deep sleep running flag
  } blk_state_t;
  blk_state_t state;
  blk_state_t next_state;

  // synchronised asynchronous inputs
  logic [10:0]                    syncVec;
  deep_sleep_wake_pkg::wake_src_t srcNow;      // sources seen in deep sleep
  deep_sleep_wake_pkg::wake_src_t firstSrc;    // first source latched
  logic                           pinLow;      // pin below input-low level
  logic                           porSync;     // supply power-on event
  logic                           supplyLoss;  // scratch contents lost
  logic                           armed;       // deep sleep running

  sync_bits #(.W(11)) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn ({faultDetect, watchdogTimeout, alarmEvent, resetPinEvent, iocEvent,
               wakeDischargePinIn, porEvent, coreBrownout, sleepBrownout,
               sleepBrownoutEnable, 1'b0}),
    .syncOut (syncVec)
  );

  assign pinLow  = ~syncVec[5];
  assign porSync = syncVec[4];
  assign armed   = (state.mode == deep_sleep_wake_pkg::MODE_DEEP);

  assign supplyLoss = porSync
                    | (syncVec[3] & !armed)
                    | (syncVec[2] & syncVec[1] & armed);

  always_comb begin
    srcNow        = '0;
    srcNow.fault  = syncVec[10];
    srcNow.wdt    = syncVec[9];
    srcNow.rtc    = syncVec[8];
    srcNow.rstPin = syncVec[7];
    srcNow.ioc    = syncVec[6];
    srcNow.ulp    = pinLow & state.wdtCtrl[deep_sleep_wake_pkg::BIT_MODEN];
    if (!armed) begin
      srcNow = '0;
    end
  end

  wake_first_select u_first (
    .clk    (clk),
    .resetn (resetn),
    .armed  (armed),
    .src    (srcNow),
    .first  (firstSrc)
  );

  // unimplemented bits zero
  // read mux, unimplemented bits masked to zero
  function automatic logic [7:0] read_reg(input logic [11:0] a, input blk_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == deep_sleep_wake_pkg::ADDR_WAKE_LOW) begin
      v = s.wakeLow & deep_sleep_wake_pkg::MASK_WAKE_LOW;
    end else if (a == deep_sleep_wake_pkg::ADDR_WAKE_HIGH) begin
      v = s.wakeHigh & deep_sleep_wake_pkg::MASK_WAKE_HIGH;
    end else if (a == deep_sleep_wake_pkg::ADDR_SCRATCH0) begin
      v = s.scratch0;
    end else if (a == deep_sleep_wake_pkg::ADDR_SCRATCH1) begin
      v = s.scratch1;
    end else if (a == deep_sleep_wake_pkg::ADDR_WDT_CTRL) begin
      v = s.wdtCtrl & deep_sleep_wake_pkg::MASK_WDT_CTRL;
    end
    return v;
  endfunction : read_reg

  // next state of the block
  always_comb begin
    next_state          = state;
    next_state.coreWake = 1'b0;
    next_state.porReq   = 1'b0;

    if (regReq.wr) begin
      if (regReq.addr == deep_sleep_wake_pkg::ADDR_WAKE_LOW) begin
        next_state.wakeLow = regReq.wdata & deep_sleep_wake_pkg::MASK_WAKE_LOW;
      end else if (regReq.addr == deep_sleep_wake_pkg::ADDR_WAKE_HIGH) begin
        next_state.wakeHigh = regReq.wdata & deep_sleep_wake_pkg::MASK_WAKE_HIGH;
      end else if (regReq.addr == deep_sleep_wake_pkg::ADDR_SCRATCH0) begin
        next_state.scratch0 = regReq.wdata;
      end else if (regReq.addr == deep_sleep_wake_pkg::ADDR_SCRATCH1) begin
        next_state.scratch1 = regReq.wdata;
      end else if (regReq.addr == deep_sleep_wake_pkg::ADDR_WDT_CTRL) begin
        next_state.wdtCtrl = regReq.wdata & deep_sleep_wake_pkg::MASK_WDT_CTRL;
      end
    end

    // read answer stands one cycle after the strobe
    next_state.rdata = regReq.rd ? read_reg(regReq.addr, state) : 8'h00;

    // power mode sequencing
    case (state.mode)
      deep_sleep_wake_pkg::MODE_RUN: begin
        if (deepSleepReq) begin
          next_state.mode = deep_sleep_wake_pkg::MODE_DEEP;
        end else if (sleepReq) begin
          next_state.mode = deep_sleep_wake_pkg::MODE_SLEEP;
        end
      end
      deep_sleep_wake_pkg::MODE_SLEEP: begin
        if (pinLow && state.wdtCtrl[deep_sleep_wake_pkg::BIT_MODEN]) begin
          next_state.mode     = deep_sleep_wake_pkg::MODE_RUN;
          next_state.coreWake = 1'b1;
          next_state.wdtCtrl[deep_sleep_wake_pkg::BIT_LEVEL] = 1'b1;
        end else if (srcNow != '0 || syncVec[6]) begin
          next_state.mode     = deep_sleep_wake_pkg::MODE_RUN;
          next_state.coreWake = 1'b1;
        end
      end
      deep_sleep_wake_pkg::MODE_DEEP: begin
        if (firstSrc != '0) begin
          next_state.mode   = deep_sleep_wake_pkg::MODE_RUN;
          next_state.porReq = 1'b1;
          if (firstSrc.fault) next_state.wakeLow[deep_sleep_wake_pkg::BIT_FAULT] = 1'b1;
          if (firstSrc.ulp) next_state.wakeLow[deep_sleep_wake_pkg::BIT_ULP] = 1'b1;
          if (firstSrc.wdt) next_state.wakeLow[deep_sleep_wake_pkg::BIT_WDT] = 1'b1;
          if (firstSrc.rtc) next_state.wakeLow[deep_sleep_wake_pkg::BIT_RTC] = 1'b1;
          if (firstSrc.rstPin) next_state.wakeLow[deep_sleep_wake_pkg::BIT_RSTPIN] = 1'b1;
          if (firstSrc.ioc) next_state.wakeHigh[deep_sleep_wake_pkg::BIT_IOC] = 1'b1;
        end
      end
      default: begin
        next_state.mode = deep_sleep_wake_pkg::MODE_RUN;
      end
    endcase

    // power-on flag, set wins over write
    if (porSync) begin
      next_state.wakeLow[deep_sleep_wake_pkg::BIT_POR] = 1'b1;
    end

    if (supplyLoss) begin
      next_state.scratch0 = deep_sleep_wake_pkg::RST_SCRATCH;
      next_state.scratch1 = deep_sleep_wake_pkg::RST_SCRATCH;
    end

    next_state.sinkOn = next_state.wdtCtrl[deep_sleep_wake_pkg::BIT_MODEN]
                      & next_state.wdtCtrl[deep_sleep_wake_pkg::BIT_SINKEN];

    // wake output only from sleep
    // follows the mode before the wake, so it shows as the core wakes
    next_state.wakeOut = (state.mode == deep_sleep_wake_pkg::MODE_SLEEP)
                       & state.wdtCtrl[deep_sleep_wake_pkg::BIT_MODEN] & pinLow;

    // deep sleep indication kept in a flop for the output
    next_state.deepOut = (next_state.mode == deep_sleep_wake_pkg::MODE_DEEP);
  end

  // register the block state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state          <= '0;
      state.mode     <= deep_sleep_wake_pkg::MODE_RUN;
      state.wakeLow  <= deep_sleep_wake_pkg::RST_WAKE_LOW;
      state.wakeHigh <= deep_sleep_wake_pkg::RST_WAKE_HIGH;
      state.wdtCtrl  <= deep_sleep_wake_pkg::RST_WDT_CTRL;
      state.scratch0 <= deep_sleep_wake_pkg::RST_SCRATCH;
      state.scratch1 <= deep_sleep_wake_pkg::RST_SCRATCH;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flops, pin output tied low
  assign rdata               = state.rdata;
  assign wakeDischargePinOut = 1'b0;
  assign wakeDischargePinOe  = state.sinkOn;
  assign dischargeWakeOutput = state.wakeOut;
  assign coreWake            = state.coreWake;
  assign porSequenceReq      = state.porReq;
  assign inDeepSleep         = state.deepOut;

  // checks next to the logic
  a_sink_enables: assert property (@(posedge clk) disable iff (!resetn)
    state.sinkOn |-> (state.wdtCtrl[1] && state.wdtCtrl[0]))
    else $error("pin sinks without both enables");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn)
    ((state.wakeLow & 8'h42) == 8'h00) && ((state.wakeHigh & 8'hfe) == 8'h00))
    else $error("unimplemented wake bit set");
  a_por_flag: assert property (@(posedge clk) disable iff (!resetn)
    porSync |=> state.wakeLow[0])
    else $error("power-on flag not set");
  a_fault_exit: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.fault) |=> (state.porReq && state.wakeLow[7] && !armed))
    else $error("fault did not leave deep sleep");
  a_ulp_flag: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.ulp) |=> state.wakeLow[5])
    else $error("pin discharge flag missing");
  a_wdt_flag: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.wdt) |=> state.wakeLow[4])
    else $error("watchdog flag missing");
  a_rtc_flag: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.rtc) |=> state.wakeLow[3])
    else $error("alarm flag missing");
  a_rst_flag: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.rstPin) |=> state.wakeLow[2])
    else $error("reset pin flag missing");
  a_ioc_flag: assert property (@(posedge clk) disable iff (!resetn)
    (armed && firstSrc.ioc) |=> state.wakeHigh[0])
    else $error("ioc flag missing");
  a_sleep_wake: assert property (@(posedge clk) disable iff (!resetn)
    (state.mode == deep_sleep_wake_pkg::MODE_SLEEP && pinLow && state.wdtCtrl[1])
    |=> (state.coreWake && state.wdtCtrl[5]))
    else $error("sleep wake did not set level flag");
  a_scratch_keep: assert property (@(posedge clk) disable iff (!resetn)
    (!regReq.wr && !supplyLoss) |=> $stable(state.scratch0))
    else $error("scratch changed without cause");

  // scratch bytes take a write unless the supply is lost the same cycle
  a_scratch_write: assert property (@(posedge clk) disable iff (!resetn)
    (regReq.wr && regReq.addr == deep_sleep_wake_pkg::ADDR_SCRATCH1 && !supplyLoss)
    |=> (state.scratch1 == $past(regReq.wdata)))
    else $error("scratch write lost");

  // a supply loss event wipes both scratch bytes
  a_scratch_loss: assert property (@(posedge clk) disable iff (!resetn)
    supplyLoss |=> (state.scratch0 == deep_sleep_wake_pkg::RST_SCRATCH
                    && state.scratch1 == deep_sleep_wake_pkg::RST_SCRATCH))
    else $error("scratch kept through supply loss");

  // outside deep sleep the high byte moves only by a write
  a_ioc_deep_only: assert property (@(posedge clk) disable iff (!resetn)
    (!armed && !regReq.wr) |=> $stable(state.wakeHigh))
    else $error("ioc flag changed outside deep sleep");

  // the wake output rises only from sleep with a low pin
  a_wake_out_sleep: assert property (@(posedge clk) disable iff (!resetn)
    (state.mode != deep_sleep_wake_pkg::MODE_SLEEP) |=> !state.wakeOut)
    else $error("wake output outside sleep");
  a_wake_out_rise: assert property (@(posedge clk) disable iff (!resetn)
    (state.mode == deep_sleep_wake_pkg::MODE_SLEEP && pinLow
     && state.wdtCtrl[deep_sleep_wake_pkg::BIT_MODEN]) |=> state.wakeOut)
    else $error("wake output missing in sleep");

  // unimplemented high bits never reach the read answer
  a_high_read_zero: assert property (@(posedge clk) disable iff (!resetn)
    (regReq.rd && regReq.addr == deep_sleep_wake_pkg::ADDR_WAKE_HIGH)
    |=> ((state.rdata & ~deep_sleep_wake_pkg::MASK_WAKE_HIGH) == 8'h00))
    else $error("unimplemented high bit read as one");

  // the deep-sleep exit pulse lasts a single cycle
  a_exit_pulse: assert property (@(posedge clk) disable iff (!resetn)
    state.porReq |=> !state.porReq)
    else $error("exit pulse longer than one cycle");
endmodule : deep_sleep_wake_status
`default_nettype wire

// File: verification/rc_discharge_model.sv
// Purpose: external capacitor and resistor on the wake discharge pin
// Assumes: one step of voltage lost per clock while the pin sinks
// Notes: the pin reads high until the voltage falls to the threshold
`timescale 1ns/10ps
`default_nettype none
module rc_discharge_model #(
  parameter int DEPTH  = 40, // charged voltage in steps
  parameter int THRESH = 10  // input-low threshold in steps
) (
  input  wire logic clk,
  input  wire logic chargeHold,
  input  wire logic sinkOe,
  input  wire logic sinkOut,
  output var  logic pinLevel
);
  int charge = 0; // capacitor voltage in steps

  // charge before sleep
  // software drives the pin high to fill the capacitor, then lets go
  always @(posedge clk) begin
    if (chargeHold) begin
      charge <= DEPTH;
    end else if (sinkOe && !sinkOut && charge > 0) begin
      charge <= charge - 1;
    end
  end

  // slow fall crosses the threshold once
  always_comb begin
    pinLevel = (charge > THRESH);
  end
endmodule : rc_discharge_model
`default_nettype wire

// File: verification/deep_sleep_wake_status_bench.sv
// Purpose: self-checking bench for the deep-sleep wake status block
// Assumes: register port strobes one cycle, inputs driven at rising edge
// Notes: ordinary cases are table rows; wake and power cases follow
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_wake_status_bench;
  typedef struct packed {
    logic        doWr;  // write before the read
    logic [11:0] addr;  // register address
    logic [7:0]  wdata; // value written
    logic [7:0]  exp;   // value read back
  } row_t;
  logic clk, resetn, sleepReq, deepSleepReq, porEvent, coreBrownout;
  logic sleepBrownout, sleepBrownoutEnable, faultDetect, watchdogTimeout;
  logic alarmEvent, resetPinEvent, iocEvent, pinIn, pinOut, pinOe, wakeOut;
  logic coreWake, porSequenceReq, inDeepSleep, chargeHold, sawOut;
  logic [7:0] rdByte; // read data
  deep_sleep_wake_pkg::reg_req_t regReq; // register request
  int fails = 0;
  int compares = 0;
  row_t rows[13] = '{
    '{1'b0, 12'hf4a, 8'h00, 8'h01}, '{1'b0, 12'hf4b, 8'h00, 8'h00},
    '{1'b0, 12'hf4e, 8'h00, 8'h00}, '{1'b0, 12'hf4f, 8'h00, 8'h00},
    '{1'b0, 12'hf50, 8'h00, 8'h00}, '{1'b1, 12'hf4e, 8'h5a, 8'h5a},
    '{1'b1, 12'hf4f, 8'ha5, 8'ha5}, '{1'b1, 12'hf4a, 8'hff, 8'hbd},
    '{1'b1, 12'hf4a, 8'h00, 8'h00}, '{1'b1, 12'hf4b, 8'hff, 8'h01},
    '{1'b1, 12'hf4b, 8'h00, 8'h00}, '{1'b1, 12'hf4c, 8'hff, 8'h00},
    '{1'b1, 12'hf50, 8'h02, 8'h02}};

  deep_sleep_wake_status i_deep_sleep_wake_status (
    .clk(clk), .resetn(resetn), .regReq(regReq), .rdata(rdByte),
    .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .porEvent(porEvent),
    .coreBrownout(coreBrownout), .sleepBrownout(sleepBrownout),
    .sleepBrownoutEnable(sleepBrownoutEnable), .faultDetect(faultDetect),
    .watchdogTimeout(watchdogTimeout), .alarmEvent(alarmEvent),
    .resetPinEvent(resetPinEvent), .iocEvent(iocEvent),
    .wakeDischargePinIn(pinIn), .wakeDischargePinOut(pinOut),
    .wakeDischargePinOe(pinOe), .dischargeWakeOutput(wakeOut),
    .coreWake(coreWake), .porSequenceReq(porSequenceReq),
    .inDeepSleep(inDeepSleep));
  rc_discharge_model i_rc_discharge_model (
    .clk(clk), .chargeHold(chargeHold), .sinkOe(pinOe), .sinkOut(pinOut),
    .pinLevel(pinIn));

  // clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // verdict and end of run
  task automatic stop_test();
    $display("counts: compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // one-cycle write strobe
  task automatic regWrite(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : regWrite

  // one-cycle read strobe, data taken in the cycle after
  task automatic regRead(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    check(what, exp, rdByte);
  endtask : regRead

  // bounded wait: 0 deep sleep running, 1 restart pulse, else core wake
  task automatic waitFor(input int which, input int bound);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < bound && !hit; i++) begin
      @(posedge clk);
      #1;
      case (which)
        0: hit = (inDeepSleep === 1'b1);
        1: hit = (porSequenceReq === 1'b1);
        default: hit = (coreWake === 1'b1);
      endcase
      if (wakeOut === 1'b1) sawOut = 1'b1;
    end
    if (!hit) begin
      fails++;
      $display("Error wait %0d expected 1 seen 0", which);
      stop_test();
    end
  endtask : waitFor

  // wake source select, unknown index drives nothing
  task automatic setSrc(input int s, input logic v);
    case (s)
      0: faultDetect <= v;
      1: watchdogTimeout <= v;
      2: alarmEvent <= v;
      3: resetPinEvent <= v;
      4: iocEvent <= v;
      default: ;
    endcase
  endtask : setSrc

  // clear the log, then enter deep sleep
  task automatic enterDeep();
    regWrite(12'hf4a, 8'h00);
    regWrite(12'hf4b, 8'h00);
    @(posedge clk);
    deepSleepReq <= 1'b1;
    @(posedge clk);
    deepSleepReq <= 1'b0;
    waitFor(0, 10);
  endtask : enterDeep

  // source a, then b after gap cycles; check log and retained scratch
  task automatic deepCase(input int a, input int b, input int gap,
                          input logic [7:0] eLow, input logic [7:0] eHigh);
    enterDeep();
    @(posedge clk);
    setSrc(a, 1'b1);
    repeat (gap) @(posedge clk);
    setSrc(b, 1'b1);
    waitFor(1, 60);
    @(posedge clk);
    setSrc(a, 1'b0);
    setSrc(b, 1'b0);
    regRead(12'hf4a, eLow, "wake low");
    regRead(12'hf4b, eHigh, "wake high");
    regRead(12'hf4e, 8'h5a, "scratch kept");
  endtask : deepCase

  // supply event pulse: 0 power-on, 1 sleep brownout disabled, 2 core brownout
  task automatic powerEvt(input int w, input logic [7:0] eScr);
    regWrite(12'hf4e, 8'h5a);
    @(posedge clk);
    if (w == 0) porEvent <= 1'b1;
    if (w == 1) sleepBrownout <= 1'b1;
    if (w == 2) coreBrownout <= 1'b1;
    repeat (3) @(posedge clk);
    porEvent <= 1'b0;
    sleepBrownout <= 1'b0;
    coreBrownout <= 1'b0;
    repeat (4) @(posedge clk);
    regRead(12'hf4e, eScr, "scratch supply");
  endtask : powerEvt

  // main sequence
  initial begin
    resetn = 1'b0;
    regReq = '0;
    {sleepReq, deepSleepReq, porEvent, coreBrownout, sleepBrownout} = '0;
    {sleepBrownoutEnable, faultDetect, watchdogTimeout, alarmEvent} = '0;
    {resetPinEvent, iocEvent, chargeHold, sawOut} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      if (rows[i].doWr) regWrite(rows[i].addr, rows[i].wdata);
      regRead(rows[i].addr, rows[i].exp, $sformatf("row %0d", i));
    end
    $display("test registers done");
    for (int v = 0; v < 4; v++) begin
      regWrite(12'hf50, v[7:0]);
      repeat (2) @(posedge clk);
      #1;
      check("sink enable", {7'h00, v == 3}, {7'h00, pinOe});
    end
    regWrite(12'hf50, 8'h00);
    $display("test sink done");
    deepCase(0, 9, 0, 8'h80, 8'h00);
    deepCase(1, 9, 0, 8'h10, 8'h00);
    deepCase(2, 9, 0, 8'h08, 8'h00);
    deepCase(3, 9, 0, 8'h04, 8'h00);
    deepCase(4, 9, 0, 8'h00, 8'h01);
    deepCase(2, 1, 1, 8'h08, 8'h00);
    deepCase(0, 4, 0, 8'h80, 8'h00);
    chargeHold <= 1'b1;
    regWrite(12'hf50, 8'h03);
    chargeHold <= 1'b0;
    deepCase(9, 9, 0, 8'h20, 8'h00);
    regWrite(12'hf50, 8'h00);
    $display("test deep sleep done");
    chargeHold <= 1'b1;
    regWrite(12'hf50, 8'h03);
    chargeHold <= 1'b0;
    @(posedge clk);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    sawOut = 1'b0;
    waitFor(2, 100);
    check("wake output", 8'h01, {7'h00, sawOut});
    regRead(12'hf50, 8'h23, "level flag");
    regWrite(12'hf50, 8'h00);
    $display("test sleep wake done");
    regWrite(12'hf4a, 8'h00);
    powerEvt(0, 8'h00);
    regRead(12'hf4a, 8'h01, "power-on flag");
    powerEvt(1, 8'h5a);
    powerEvt(2, 8'h00);
    $display("test supply done");
    regWrite(12'hf4a, 8'hbc);
    regWrite(12'hf50, 8'h23);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    regRead(12'hf4a, 8'h01, "reset wake low");
    regRead(12'hf50, 8'h00, "reset control");
    $display("test reset done");
    stop_test();
  end
endmodule : deep_sleep_wake_status_bench
`default_nettype wire
